// ---- tib_char_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tib_consts.svh"
module tib_char_capture #(
  parameter int SKEW_CYCLES = `TIB_SKEW_US * `TIB_CLK_MHZ,
  parameter int HOLD_CYCLES = `TIB_HOLD_US * `TIB_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic tape_clk,
  input wire logic [5:0] tape_char,
  input wire logic clock_test_cmd,
  input wire logic clear_cmd,
  input wire logic load_cmd,
  output logic clock_seen,
  output logic [5:0] char_buf
);
  logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
  logic [5:0] dat_s1_reg, dat_s2_reg;
  logic seen_reg, seen_next;
  logic [16:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic [5:0] buf_reg, buf_next;
  logic edge_hit;

  assign edge_hit = clk_s2_reg & ~clk_s3_reg;
  assign clock_seen = seen_reg;
  assign char_buf = buf_reg;

  always_comb begin
    seen_next = seen_reg;
    if (clock_test_cmd) begin
      seen_next = 1'b0;
    end
    // Set beats clear
    if (edge_hit) begin
      seen_next = 1'b1;
    end
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    if (edge_hit) begin
      busy_next = 1'b1;
      cnt_next = 17'h0_0000;
    end else if (busy_reg) begin
      if (cnt_reg == 17'(HOLD_CYCLES)) begin
        busy_next = 1'b0;
      end else begin
        cnt_next = cnt_reg + 17'h0_0001;
      end
    end
    buf_next = buf_reg;
    if (clear_cmd || load_cmd) begin
      buf_next = 6'h00;
    end
    // Ones collected only inside the skew-to-hold window, riding out lagging tracks
    if (busy_reg && !edge_hit && cnt_reg >= 17'(SKEW_CYCLES)) begin
      buf_next = buf_next | dat_s2_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
      dat_s1_reg <= 6'h00;
      dat_s2_reg <= 6'h00;
      seen_reg <= 1'b0;
      cnt_reg <= 17'h0_0000;
      busy_reg <= 1'b0;
      buf_reg <= 6'h00;
    end else begin
      clk_s1_reg <= tape_clk;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      dat_s1_reg <= tape_char;
      dat_s2_reg <= dat_s1_reg;
      seen_reg <= seen_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      buf_reg <= buf_next;
    end
  end
endmodule : tib_char_capture
`default_nettype wire

// ---- tib_consts.svh ----
`ifndef TIB_CONSTS_SVH
`define TIB_CONSTS_SVH
`define TIB_CLK_MHZ 250
`define TIB_SKEW_US 36
`define TIB_HOLD_US 232
`define TIB_PT_PER_WORD 24
`define TIB_WORDS_PER_CYCLE 256
`define TIB_GROUP_WORDS 16
`define TIB_IR_DELAY 22
`define TIB_CHAR_BITS 6
`define TIB_GROUP_BASE 8'hFF
`define TIB_DUMP_LINE 6'h0F
`endif

// ---- tib_pkg.sv ----
package tib_pkg;
  typedef enum logic [3:0] {
    TIB_IDLE = 4'b0001,
    TIB_SWAP = 4'b0010,
    TIB_WAIT = 4'b0100,
    TIB_PREC = 4'b1000
  } tib_state_t;
endpackage : tib_pkg

// ---- tib_tape_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tib_tape_model (
  output logic tape_clk,
  output logic [5:0] tape_char
);
  logic lclk = 1'b0;
  logic busy = 1'b0;
  initial begin
    tape_clk = 1'b0;
    tape_char = 6'h00;
    #5.3;
    forever #24 lclk = ~lclk;
  end
  // Idle lines keep moving so stale bits never pass as data
  always @(posedge lclk) if (!busy) tape_char <= ~tape_char;
  task automatic put(input logic [5:0] c);
    busy = 1'b1;
    for (int i = 0; i < 14; i++) begin
      @(posedge lclk);
      tape_clk <= (i < 10);
      tape_char <= (i > 0 && i < 10) ? c : c ^ 6'(i + 21);
    end
    busy <= 1'b0;
  endtask : put
endmodule : tib_tape_model
`default_nettype wire

// ---- tib_testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tib_consts.svh"
module testbench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] cmds = 8'h00;
  logic [5:0] xline = 6'h00;
  logic [7:0] addr = 8'h00;
  logic eob = 1'b0;
  logic ctr, gc, eobs, p1, p2;
  logic [23:0] acc, l4d;
  logic [23:0] words [32];
  wire tclk;
  wire [5:0] tch;
  int fails = 0;
  int tests_run = 0;
  int unsigned seed = 83;
  int unsigned macc = 0;
  tib_tape_model u_tape (.tape_clk(tclk), .tape_char(tch));
  tib_transfer #(.SKEW_CYCLES(20), .HOLD_CYCLES(100)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .tape_clk(tclk), .tape_char(tch), .end_of_block(eob),
    .peripheral_transfer_cmd(cmds[0]), .transfer_line(xline), .input_clock_test_cmd(cmds[1]),
    .clear_input_buffer_cmd(cmds[2]), .load_input_char_cmd(cmds[3]),
    .shift_accum_left_cmd(cmds[4]), .precess_to_fast_line_cmd(cmds[5]),
    .group_count_test_cmd(cmds[6]), .line_four_addr(addr), .clock_test_result(ctr),
    .group_complete(gc), .end_of_block_seen(eobs), .phase_one(p1), .phase_two(p2),
    .accum_word(acc), .line_four_data(l4d));
  initial forever #2 core_clk = ~core_clk;
  // About four times the expected run
  initial begin
    #400000;
    fails++;
    test_done();
  end
  function automatic logic [23:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[23:0];
  endfunction : rnd
  task automatic cmp(input string n, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  task automatic go(input logic [7:0] m);
    @(posedge core_clk) cmds <= m;
    @(posedge core_clk) cmds <= 8'h00;
    #1;
  endtask : go
  task automatic get_char(input logic [5:0] c);
    int n;
    n = 0;
    do begin
      go(8'h02);
      n++;
    end while (ctr !== 1'b1 && n < 100);
    cmp("clk", 24'h00_0001, 24'(ctr));
    go(8'h04);
    repeat (110) @(posedge core_clk);
    go(8'h18);
    macc = ((macc << 6) | c) & 32'h00FF_FFFF;
    cmp("acc", macc[23:0], acc);
  endtask : get_char
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    logic [5:0] c;
    int n;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    go(8'h02);
    cmp("clk", 24'h00_0000, 24'(ctr));
    cmp("eob", 24'h00_0000, 24'(eobs));
    for (int g = 0; g < 2; g++) begin
      for (int w = 0; w < 16; w++) begin
        c = 6'(rnd());
        fork
          u_tape.put(c);
          get_char(c);
        join
        if (rnd() > 24'h7F_FFFF) begin
          go(8'h10);
          macc = (macc << 6) & 32'h00FF_FFFF;
          cmp("acc", macc[23:0], acc);
        end
        go(8'h20);
        words[g * 16 + w] = macc[23:0];
        go(8'h40);
        cmp("full", 24'(w == 15), 24'(gc));
      end
      @(posedge core_clk) xline <= `TIB_DUMP_LINE ^ 6'h01;
      go(8'h01);
      repeat (40) @(posedge core_clk);
      cmp("bad", 24'h00_0000, 24'({p2, p1}));
      @(posedge core_clk) xline <= `TIB_DUMP_LINE;
      go(8'h01);
      n = 0;
      while (p2 !== 1'b1 && n < 20000) begin
        @(posedge core_clk);
        #1;
        n++;
      end
      while ({p2, p1} !== 2'b00 && n < 20000) begin
        @(posedge core_clk);
        #1;
        n++;
      end
      cmp("dump", 24'h00_0000, 24'({n >= 20000, p2, p1}));
      $display("test group %0d done", g);
    end
    @(posedge core_clk) eob <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    cmp("eob", 24'h00_0001, 24'(eobs));
    for (int w = 0; w < 32; w++) begin
      @(posedge core_clk) addr <= `TIB_GROUP_BASE + 8'(w);
      repeat (2) @(posedge core_clk);
      #1;
      cmp("l4", words[w], l4d);
    end
    $display("test line four done");
    test_done();
  end
endmodule : testbench
`default_nettype wire

// ---- tib_transfer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tib_consts.svh"
// Function
// - Sequencer idle, phases clear, until transfer command
// - Phase one: swap fast and buffer lines
// - Both phases: wait for machine cycle start
// - Phase two: precess line four one cycle
// - Transfer command decoded by line number, starts
// - Characters accepted only after clock detected
// - Blocks at most 272 words, 816 characters
// - Six-bit characters, three or four per word
// - Groups land consecutively in line four
// - All flip-flops change on pulse-time clock
// - Read flip-flop follows write after 22
// - Line decode gates a line number latched into line_hold_reg
// - Character buffer cleared before each character
module tib_transfer #(
  parameter int SKEW_CYCLES = `TIB_SKEW_US * `TIB_CLK_MHZ,
  parameter int HOLD_CYCLES = `TIB_HOLD_US * `TIB_CLK_MHZ,
  parameter logic [5:0] DUMP_LINE = `TIB_DUMP_LINE,
  parameter logic [7:0] GROUP_BASE = `TIB_GROUP_BASE,
  parameter int WORD_BITS = 24
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic tape_clk,
  input wire logic [5:0] tape_char,
  input wire logic end_of_block,
  input wire logic peripheral_transfer_cmd,
  input wire logic [5:0] transfer_line,
  input wire logic input_clock_test_cmd,
  input wire logic clear_input_buffer_cmd,
  input wire logic load_input_char_cmd,
  input wire logic shift_accum_left_cmd,
  input wire logic precess_to_fast_line_cmd,
  input wire logic group_count_test_cmd,
  input wire logic [7:0] line_four_addr,
  output logic clock_test_result,
  output logic group_complete,
  output logic end_of_block_seen,
  output logic phase_one,
  output logic phase_two,
  output logic [WORD_BITS-1:0] accum_word,
  output logic [WORD_BITS-1:0] line_four_data
);
  logic [WORD_BITS-1:0] fast_access_line [0:15];
  logic [WORD_BITS-1:0] group_buffer_line [0:15];
  logic [WORD_BITS-1:0] long_line_four [0:255];

  tib_pkg::tib_state_t st_reg, st_next;
  logic [4:0] pt_reg, pt_next;
  logic [7:0] sector_reg, sector_next;
  logic [8:0] wcnt_reg, wcnt_next;
  logic [7:0] group_ptr_reg, group_ptr_next;
  logic [4:0] fill_reg, fill_next;
  logic [WORD_BITS-1:0] acc_reg, acc_next;
  logic instr_write_ff;
  logic [`TIB_IR_DELAY-1:0] ir_dly_reg;
  logic instr_read_ff;
  logic [5:0] line_hold_reg;
  logic eob_s1_reg, eob_s2_reg;
  logic test_reg, grp_reg;
  logic phase_one_reg, phase_one_next;
  logic phase_two_reg, phase_two_next;
  logic [WORD_BITS-1:0] rd_reg;
  logic clock_seen;
  logic [5:0] char_buf;
  logic word_edge, dump_sel, in_swap, in_prec;
  logic [3:0] slot;
  logic [7:0] l4_addr;

  tib_char_capture #(
    .SKEW_CYCLES(SKEW_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_capture (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .tape_clk(tape_clk),
    .tape_char(tape_char),
    .clock_test_cmd(input_clock_test_cmd),
    .clear_cmd(clear_input_buffer_cmd),
    .load_cmd(load_input_char_cmd),
    .clock_seen(clock_seen),
    .char_buf(char_buf)
  );

  // Ungated decodes feeding flip-flop inputs
  assign dump_sel = (line_hold_reg == DUMP_LINE);
  assign word_edge = (pt_reg == 5'(`TIB_PT_PER_WORD - 1));
  assign slot = sector_reg[3:0];
  assign l4_addr = group_ptr_reg + sector_reg;
  assign in_swap = (st_reg == tib_pkg::TIB_SWAP);
  assign in_prec = (st_reg == tib_pkg::TIB_PREC) && (sector_reg < 8'(`TIB_GROUP_WORDS));

  always_comb begin
    pt_next = word_edge ? 5'h00 : pt_reg + 5'h01;
    sector_next = word_edge ? sector_reg + 8'h01 : sector_reg;
    st_next = st_reg;
    wcnt_next = wcnt_reg;
    group_ptr_next = group_ptr_reg;
    unique case (st_reg)
      tib_pkg::TIB_IDLE: begin
        if (instr_read_ff && dump_sel) begin
          st_next = tib_pkg::TIB_SWAP;
          wcnt_next = 9'h000;
        end
      end
      tib_pkg::TIB_SWAP: begin
        if (word_edge) begin
          wcnt_next = wcnt_reg + 9'h001;
          if (wcnt_reg == 9'(`TIB_GROUP_WORDS - 1)) begin
            st_next = tib_pkg::TIB_WAIT;
          end
        end
      end
      tib_pkg::TIB_WAIT: begin
        if (word_edge && sector_reg == 8'hFF) begin
          st_next = tib_pkg::TIB_PREC;
          wcnt_next = 9'h000;
        end
      end
      tib_pkg::TIB_PREC: begin
        if (word_edge) begin
          wcnt_next = wcnt_reg + 9'h001;
          if (wcnt_reg == 9'(`TIB_WORDS_PER_CYCLE - 1)) begin
            st_next = tib_pkg::TIB_IDLE;
            group_ptr_next = group_ptr_reg + 8'(`TIB_GROUP_WORDS);
          end
        end
      end
    endcase
    phase_one_next = (st_next == tib_pkg::TIB_SWAP) || (st_next == tib_pkg::TIB_WAIT);
    phase_two_next = (st_next == tib_pkg::TIB_WAIT) || (st_next == tib_pkg::TIB_PREC);
    acc_next = acc_reg;
    if (shift_accum_left_cmd) begin
      acc_next = acc_reg << `TIB_CHAR_BITS;
    end
    if (load_input_char_cmd) begin
      acc_next[5:0] = acc_next[5:0] | char_buf;
    end
    fill_next = fill_reg;
    if (st_reg == tib_pkg::TIB_PREC && st_next == tib_pkg::TIB_IDLE) begin
      fill_next = 5'h00;
    end
    if (precess_to_fast_line_cmd && fill_reg != 5'(`TIB_GROUP_WORDS)) begin
      fill_next = fill_reg + 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_reg <= tib_pkg::TIB_IDLE;
      phase_one_reg <= 1'b0;
      phase_two_reg <= 1'b0;
      pt_reg <= 5'h00;
      sector_reg <= 8'h00;
      wcnt_reg <= 9'h000;
      group_ptr_reg <= GROUP_BASE;
      fill_reg <= 5'h00;
      acc_reg <= '0;
      instr_write_ff <= 1'b0;
      ir_dly_reg <= '0;
      line_hold_reg <= 6'h00;
      eob_s1_reg <= 1'b0;
      eob_s2_reg <= 1'b0;
      test_reg <= 1'b0;
      grp_reg <= 1'b0;
      rd_reg <= '0;
    end else begin
      st_reg <= st_next;
      phase_one_reg <= phase_one_next;
      phase_two_reg <= phase_two_next;
      pt_reg <= pt_next;
      sector_reg <= sector_next;
      wcnt_reg <= wcnt_next;
      group_ptr_reg <= group_ptr_next;
      fill_reg <= fill_next;
      acc_reg <= acc_next;
      instr_write_ff <= peripheral_transfer_cmd;
      ir_dly_reg <= {ir_dly_reg[`TIB_IR_DELAY-2:0], instr_write_ff};
      if (peripheral_transfer_cmd) begin
        line_hold_reg <= transfer_line;
      end
      eob_s1_reg <= end_of_block;
      eob_s2_reg <= eob_s1_reg;
      if (input_clock_test_cmd) begin
        test_reg <= clock_seen;
      end
      if (group_count_test_cmd) begin
        grp_reg <= (fill_reg == 5'(`TIB_GROUP_WORDS));
      end
      rd_reg <= long_line_four[line_four_addr];
    end
  end

  assign instr_read_ff = ir_dly_reg[`TIB_IR_DELAY-1];

  // Data lines carry no reset; contents are whatever software left
  always_ff @(posedge core_clk) begin
    if (precess_to_fast_line_cmd && !in_swap) begin
      fast_access_line[fill_reg[3:0]] <= acc_reg;
    end
    if (in_swap && word_edge) begin
      group_buffer_line[slot] <= fast_access_line[slot];
      fast_access_line[slot] <= group_buffer_line[slot];
    end
    if (in_prec && word_edge) begin
      long_line_four[l4_addr] <= group_buffer_line[slot];
      group_buffer_line[slot] <= long_line_four[l4_addr];
    end
  end

  assign clock_test_result = test_reg;
  assign group_complete = grp_reg;
  assign end_of_block_seen = eob_s2_reg;
  assign phase_one = phase_one_reg;
  assign phase_two = phase_two_reg;
  assign accum_word = acc_reg;
  assign line_four_data = rd_reg;
endmodule : tib_transfer
`default_nettype wire

// ---- tib_transfer_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tib_consts.svh"
module tib_transfer_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic peripheral_transfer_cmd,
  input wire logic [5:0] transfer_line,
  input wire logic shift_accum_left_cmd,
  input wire logic load_input_char_cmd,
  input wire logic phase_one,
  input wire logic phase_two,
  input wire logic [23:0] accum_word
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic idle;
  logic [12:0] cnt_reg;
  logic [12:0] cnt_next;
  assign idle = !phase_one && !phase_two;
  // Pulses spent precessing; one machine cycle is 6144
  always_comb cnt_next = (phase_two && !phase_one) ? cnt_reg + 13'h0001 : 13'h0000;
  always_ff @(posedge core_clk) cnt_reg <= rst_b ? cnt_next : 13'h0000;
  a_start_seq: assert property (peripheral_transfer_cmd && idle
    && transfer_line == `TIB_DUMP_LINE |=> !phase_one [*8] ##[10:40] phase_one)
    else $error("start");
  a_wrong_line: assert property (peripheral_transfer_cmd && idle
    && transfer_line != `TIB_DUMP_LINE |=> idle [*8] ##16 idle [*8]) else $error("bad line");
  a_swap_first: assert property ($rose(phase_one) |-> !phase_two) else $error("swap");
  a_swap_wait: assert property ($rose(phase_two) |-> $past(phase_one)) else $error("wait");
  a_wait_prec: assert property ($fell(phase_one) |-> $past(phase_two)) else $error("prec");
  a_prec_idle: assert property ($fell(phase_two) |-> !$past(phase_one)) else $error("end");
  a_prec_len: assert property ($fell(phase_two) |-> cnt_reg inside {[13'h17FF:13'h1801]})
    else $error("length");
  a_accum_shift: assert property (shift_accum_left_cmd && !load_input_char_cmd
    |=> accum_word == {$past(accum_word[17:0]), 6'h00}) else $error("shift");
  c_dump: cover property ($fell(phase_two));
  c_both: cover property (shift_accum_left_cmd && load_input_char_cmd);
  c_wait: cover property (phase_one && phase_two);
endmodule : tib_transfer_chk
bind tib_transfer tib_transfer_chk u_chk (.*);
`default_nettype wire
